// >>> rtl/prps_crossbar.v
// Purpose: remappable peripheral pin-select crossbar with APB registers
// Assumes: pins and peripheral outputs arrive asynchronously
// Notes:   port data/direction logic lives outside this block
`timescale 1ns/10ps
`default_nettype none
`include "prps_consts.vh"

module prps_crossbar (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         psel,
	input  wire         penable,
	input  wire         pwrite,
	input  wire [11:0]  paddr,
	input  wire [31:0]  pwdata,
	output reg          pready,
	output reg  [31:0]  prdata,
	output reg          pslverr,
	input  wire         one_way_lock_cfg,
	input  wire [29:0]  remap_pin_in,
	input  wire [15:0]  periph_out,
	output reg  [22:0]  periph_in,
	output reg  [29:0]  remap_pin_out,
	output reg  [29:0]  remap_pin_own,
	output reg          mapping_lock_bit,
	output reg          cfg_mismatch_reset
);

	localparam NIN = `PRPS_NUM_IN;
	localparam NP  = `PRPS_NUM_PINS;
	localparam [5:0] NIN6      = NIN[5:0];
	localparam [5:0] VIRT_BASE = 6'h20;
	localparam [5:0] PIN_SPAN  = 6'h24;

	//--------------------------------------------------------------
	// reset release and input synchronisers
	//--------------------------------------------------------------
	reg        rst_s1_r;
	reg        rst_s2_r;
	wire       rst_sync_n = rst_s2_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// one-way option reads as set while in reset
	reg [29:0] pin_s1_r;
	reg [29:0] pin_s2_r;
	reg [15:0] po_s1_r;
	reg [15:0] po_s2_r;
	reg        ow_s1_r;
	reg        ow_s2_r;

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_s1_r <= 30'h0000000;
			pin_s2_r <= 30'h0000000;
			po_s1_r  <= 16'h0000;
			po_s2_r  <= 16'h0000;
			ow_s1_r  <= 1'b1;
			ow_s2_r  <= 1'b1;
		end else begin
			pin_s1_r <= remap_pin_in;
			pin_s2_r <= pin_s1_r;
			po_s1_r  <= periph_out;
			po_s2_r  <= po_s1_r;
			ow_s1_r  <= one_way_lock_cfg;
			ow_s2_r  <= ow_s1_r;
		end
	end

	//--------------------------------------------------------------
	// apb decode
	//--------------------------------------------------------------
	wire       wait_ph  = psel && penable && !pready;
	wire       acc      = psel && penable && pready;
	wire       wr_acc   = acc && pwrite;
	wire       is_osc   = (paddr == `PRPS_OSC_CTRL_OFS);
	wire       is_stat  = (paddr == `PRPS_STATUS_OFS);
	wire       aligned  = (paddr[1:0] == 2'h0);
	wire [5:0] word_no  = paddr[7:2];
	wire       is_in    = (paddr[11:8] == 4'h1) && (word_no < NIN6) && aligned;

	//--------------------------------------------------------------
	// output selector address: pins 0..29 physical, 32..35 virtual
	//--------------------------------------------------------------
	wire       pin_ok   = (word_no < 6'h1E) ||
	                      ((word_no >= VIRT_BASE) && (word_no < PIN_SPAN));
	wire [5:0] pin_slot = (word_no >= VIRT_BASE) ? (word_no - 6'h02) : word_no;
	wire       is_out   = (paddr[11:8] == 4'h2) && pin_ok && aligned;
	wire       is_sel   = is_in || is_out;
	wire [5:0] sel_idx  = is_in ? word_no : (pin_slot + NIN6);

	// one wait state: the selector read data is registered
	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			pready <= 1'b0;
		else
			pready <= wait_ph;
	end

	//--------------------------------------------------------------
	// unlock sequence and mapping lock
	//--------------------------------------------------------------
	reg  [1:0] key_r;
	reg  [1:0] key_nxt;
	reg        lock_nxt;
	reg        once_locked_r;
	wire       osc_wr = wr_acc && is_osc;
	wire [7:0] low_b  = pwdata[7:0];

	always @* begin
		key_nxt  = key_r;
		lock_nxt = mapping_lock_bit;
		// a control write off the key sequence drops it back to idle; a repeated first key keeps it at step one
		if (osc_wr) begin
			case (key_r)
			`PRPS_KS_IDLE: key_nxt = (low_b == `PRPS_KEY_ONE) ? `PRPS_KS_ONE : `PRPS_KS_IDLE;
			`PRPS_KS_ONE: key_nxt = (low_b == `PRPS_KEY_TWO) ? `PRPS_KS_OPEN :
			                    ((low_b == `PRPS_KEY_ONE) ? `PRPS_KS_ONE : `PRPS_KS_IDLE);
			`PRPS_KS_OPEN: begin
				key_nxt = `PRPS_KS_IDLE;
				if (!(ow_s2_r && once_locked_r && !pwdata[`PRPS_LOCK_BIT]))
					lock_nxt = pwdata[`PRPS_LOCK_BIT];
			end
			default: key_nxt = `PRPS_KS_IDLE;
			endcase
		end
	end

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			key_r            <= `PRPS_KS_IDLE;
			mapping_lock_bit <= `PRPS_LOCK_RST;
			once_locked_r    <= 1'b0;
		end else begin
			key_r            <= key_nxt;
			mapping_lock_bit <= lock_nxt;
			once_locked_r    <= once_locked_r | lock_nxt;
		end
	end

	//--------------------------------------------------------------
	// selector storage
	//--------------------------------------------------------------
	wire [341:0] fields;
	wire [5:0]   mem_rd;
	wire         mismatch;
	wire         sel_wr = wr_acc && is_sel && !mapping_lock_bit;

	prps_sel_mem u_mem (
		.clk        (clk),
		.rst_n      (rst_sync_n),
		.wr_en      (sel_wr),
		.wr_idx     (sel_idx),
		.wr_data    (pwdata[5:0]),
		.rd_idx     (sel_idx),
		.rd_data_r  (mem_rd),
		.fields     (fields),
		.mismatch_r (mismatch)
	);

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			cfg_mismatch_reset <= 1'b0;
		else
			cfg_mismatch_reset <= cfg_mismatch_reset | mismatch;
	end

	//--------------------------------------------------------------
	// apb read data and error
	//--------------------------------------------------------------
	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (wait_ph) begin
			// loads with the wait state so it stands beside pready
			pslverr <= !(is_osc || is_stat || is_sel);
			if (is_osc)
				prdata <= {25'h0, mapping_lock_bit, 6'h00};
			else if (is_stat)
				prdata <= {28'h0000000, cfg_mismatch_reset, once_locked_r, ow_s2_r, mapping_lock_bit};
			else if (is_sel)
				prdata <= {26'h0, mem_rd};
			else
				prdata <= 32'h00000000;
		end else begin
			pslverr <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// input mapping
	//--------------------------------------------------------------
	// pin numbers 30 and 31 are absent and read as ground
	wire [35:0] pin_level;
	wire [22:0] in_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi = gi + 1) begin : g_in
			wire [5:0] s = fields[gi*6 +: 6];
			assign in_nxt[gi] = (s < PIN_SPAN) ? pin_level[s]
			                                   : 1'b0;
		end
	endgenerate

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			periph_in <= 23'h0;
		else
			periph_in <= in_nxt;
	end

	//--------------------------------------------------------------
	// output mapping
	//--------------------------------------------------------------
	function automatic [1:0] out_mux;
		input [5:0]  code;
		input [15:0] src;
		begin
			case (code)
			`PRPS_OC_TX:     out_mux = {1'b1, src[0]};
			`PRPS_OC_RTS:    out_mux = {1'b1, src[1]};
			`PRPS_OC_SDO:    out_mux = {1'b1, src[2]};
			`PRPS_OC_SCKO:   out_mux = {1'b1, src[3]};
			`PRPS_OC_SSO:    out_mux = {1'b1, src[4]};
			`PRPS_OC_CMP1:   out_mux = {1'b1, src[5]};
			`PRPS_OC_CMP2:   out_mux = {1'b1, src[6]};
			`PRPS_OC_SYNCO:  out_mux = {1'b1, src[7]};
			`PRPS_OC_REFERENCE_CLOCK_OUT: out_mux = {1'b1, src[8]};
			`PRPS_OC_ACMP1:  out_mux = {1'b1, src[9]};
			`PRPS_OC_ACMP2:  out_mux = {1'b1, src[10]};
			`PRPS_OC_ACMP3:  out_mux = {1'b1, src[11]};
			`PRPS_OC_ACMP4:  out_mux = {1'b1, src[12]};
			`PRPS_OC_PWM_A:  out_mux = {1'b1, src[13]};
			`PRPS_OC_PWM_B:  out_mux = {1'b1, src[14]};
			default:         out_mux = 2'b00;
			endcase
		end
	endfunction

	wire [29:0] out_nxt;
	wire [29:0] own_nxt;

	genvar go;
	generate
		for (go = 0; go < NP; go = go + 1) begin : g_out
			wire [1:0] m = out_mux(fields[(NIN+go)*6 +: 6], po_s2_r);
			if (go < `PRPS_NUM_PHYS) begin : g_phys
				assign out_nxt[go]   = m[0];
				assign own_nxt[go]   = m[1];
				assign pin_level[go] = pin_s2_r[go];
			end else begin : g_virt
				// slots 30..33 hold virtual pins 32..35
				assign pin_level[go+2] = m[0];
			end
		end
	endgenerate
	assign pin_level[31:30] = 2'b00;

	// registered so every pin output leaves a flip-flop
	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			remap_pin_out <= 30'h0;
			remap_pin_own <= 30'h0;
		end else begin
			remap_pin_out <= out_nxt;
			remap_pin_own <= own_nxt;
		end
	end

endmodule // prps_crossbar

`default_nettype wire

// >>> rtl/prps_consts.vh
// Purpose: constants for the remappable pin-select crossbar
// Assumes: 32-bit APB, one register per aligned word
// Notes:   offsets are byte addresses
`ifndef PRPS_CONSTS_VH
`define PRPS_CONSTS_VH

`define PRPS_NUM_IN        23
`define PRPS_NUM_PHYS      30
`define PRPS_NUM_PINS      34
`define PRPS_NUM_OUT_SRC   16
`define PRPS_SEL_W         6

// register map
`define PRPS_OSC_CTRL_OFS  12'h000
`define PRPS_STATUS_OFS    12'h004
`define PRPS_IN_SEL_BASE   12'h100
`define PRPS_OUT_SEL_BASE  12'h200

// oscillator control fields
`define PRPS_LOCK_BIT      6
`define PRPS_KEY_ONE       8'h46
`define PRPS_KEY_TWO       8'h57
`define PRPS_ONE_WAY_BIT   5

// reset values
`define PRPS_IN_SEL_RST    6'h3F
`define PRPS_OUT_SEL_RST   6'h00
`define PRPS_LOCK_RST      1'b0

// unlock sequence states
`define PRPS_KS_IDLE       2'h0
`define PRPS_KS_ONE        2'h1
`define PRPS_KS_OPEN       2'h2

// output codes
`define PRPS_OC_NONE       6'h00
`define PRPS_OC_TX         6'h03
`define PRPS_OC_RTS        6'h04
`define PRPS_OC_SDO        6'h07
`define PRPS_OC_SCKO       6'h08
`define PRPS_OC_SSO        6'h09
`define PRPS_OC_CMP1       6'h12
`define PRPS_OC_CMP2       6'h13
`define PRPS_OC_SYNCO      6'h25
`define PRPS_OC_REFERENCE_CLOCK_OUT     6'h26
`define PRPS_OC_ACMP1      6'h27
`define PRPS_OC_ACMP2      6'h28
`define PRPS_OC_ACMP3      6'h29
`define PRPS_OC_ACMP4      6'h2A
`define PRPS_OC_PWM_A      6'h2C
`define PRPS_OC_PWM_B      6'h2D

`endif

// >>> rtl/prps_sel_mem.v
// Purpose: selector storage with shadow copy and mismatch detect
// Assumes: one write port, all fields visible at once
// Notes:   read data registered
`timescale 1ns/10ps
`default_nettype none
`include "prps_consts.vh"

module prps_sel_mem (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        wr_en,
	input  wire [5:0]  wr_idx,
	input  wire [5:0]  wr_data,
	input  wire [5:0]  rd_idx,
	output reg  [5:0]  rd_data_r,
	output wire [341:0] fields,
	output reg         mismatch_r
);

	localparam N = `PRPS_NUM_IN + `PRPS_NUM_PINS;

	wire [N-1:0] diff;

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_ent
			localparam [5:0] RST_VAL = (g < `PRPS_NUM_IN) ? `PRPS_IN_SEL_RST : `PRPS_OUT_SEL_RST;
			reg [5:0] main_r;
			reg [5:0] shadow_r;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					main_r   <= RST_VAL;
					shadow_r <= RST_VAL;
				end else if (wr_en && ({26'h0, wr_idx} == g)) begin
					main_r   <= wr_data;
					shadow_r <= wr_data;
				end
			end
			assign diff[g] = (main_r != shadow_r);
			assign fields[g*6 +: 6] = main_r;
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r  <= 6'h00;
			mismatch_r <= 1'b0;
		end else begin
			rd_data_r  <= (rd_idx < N) ? fields[rd_idx*6 +: 6] : 6'h00;
			mismatch_r <= |diff;
		end
	end

endmodule // prps_sel_mem

`default_nettype wire

// >>> bench/prps_crossbar_asserts.sv
// Purpose: port checks for the pin-select crossbar
// Assumes: one clock, rst_n async active low
// Notes:   bound to every prps_crossbar
`timescale 1ns/10ps
`default_nettype none
module prps_crossbar_asserts (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        one_way_lock_cfg,
	input wire logic [29:0] remap_pin_own,
	input wire logic        mapping_lock_bit,
	input wire logic        cfg_mismatch_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait state");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	sel_no_err_a: assert property (pready && paddr[11:8] == 4'h1 && paddr[7:0] < 8'h5C
		&& paddr[1:0] == 2'h0
		|-> !pslverr)
		else $error("selector access refused");
	locked_stable_a: assert property (mapping_lock_bit [*3] |-> $stable(remap_pin_own))
		else $error("pin ownership moved while locked");
	lock_cause_a: assert property ($changed(mapping_lock_bit)
		|-> $past(psel && penable && pready && pwrite && paddr == 12'h000))
		else $error("lock moved without control write");
	one_way_a: assert property ($fell(mapping_lock_bit) |-> !one_way_lock_cfg)
		else $error("lock cleared under one-way option");
	no_mismatch_a: assert property (!cfg_mismatch_reset)
		else $error("spurious mismatch reset");
	cover property ($rose(mapping_lock_bit));
	cover property (pready && pslverr);
	cover property ($rose(remap_pin_own[29]));
endmodule // prps_crossbar_asserts
bind prps_crossbar prps_crossbar_asserts u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.one_way_lock_cfg(one_way_lock_cfg), .remap_pin_own(remap_pin_own),
	.mapping_lock_bit(mapping_lock_bit), .cfg_mismatch_reset(cfg_mismatch_reset));
`default_nettype wire

// >>> bench/prps_far_model.sv
// Purpose: pins and peripherals around the crossbar
// Assumes: pins set as inputs by port logic
// Notes:   levels come from the bench
`timescale 1ns/10ps
`default_nettype none
module prps_far_model (
	input  wire logic [29:0] pin_lvl,
	input  wire logic [15:0] src_lvl,
	output wire logic [29:0] remap_pin_in,
	output wire logic [15:0] periph_out
);
	// pins only ever feed the crossbar
	assign remap_pin_in = pin_lvl;
	assign periph_out   = src_lvl;
endmodule // prps_far_model
`default_nettype wire

// >>> bench/prps_crossbar_tb_top.sv
// Purpose: bench for the pin-select crossbar
// Assumes: APB answer after one wait state
// Notes:   input sync latency three cycles
`timescale 1ns/10ps
`default_nettype none
`include "prps_consts.vh"
module prps_crossbar_tb_top;
	logic        clk, rst_n, psel, penable, pwrite, cfg, pready, pslverr, lock, mism, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [29:0] pin_pat, pin_in, pin_out, pin_own;
	logic [15:0] src_pat, src;
	logic [22:0] p_in;
	int          failures, num_checks;
	logic [5:0]  codes [15] = '{6'h03, 6'h04, 6'h07, 6'h08, 6'h09, 6'h12, 6'h13, 6'h25,
		6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h2C, 6'h2D};
	int          vals [4] = '{0, 29, 30, 63};
	prps_far_model far (.pin_lvl(pin_pat), .src_lvl(src_pat), .remap_pin_in(pin_in),
		.periph_out(src));
	prps_crossbar dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .one_way_lock_cfg(cfg), .remap_pin_in(pin_in), .periph_out(src),
		.periph_in(p_in), .remap_pin_out(pin_out), .remap_pin_own(pin_own),
		.mapping_lock_bit(lock), .cfg_mismatch_reset(mism));
	// --------
	// bus and helper tasks
	// --------
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'b1) begin
			failures++;
			$display("CHECK FAILED apb_ready exp 1 got %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	task key(input logic [31:0] d);
		apb(1'b1, `PRPS_OSC_CTRL_OFS, 32'h46);
		apb(1'b1, `PRPS_OSC_CTRL_OFS, 32'h57);
		apb(1'b1, `PRPS_OSC_CTRL_OFS, d);
	endtask
	task settle();
		repeat (6) @(posedge clk);
	endtask
	task do_reset(input logic ow);
		rst_n <= 1'b0;
		cfg <= ow;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, pin_pat, src_pat} = '0;
		cfg = 1'b1;
		@(posedge clk);
		do_reset(1'b1);
		rdc(`PRPS_IN_SEL_BASE, 32'h3F, "in_sel_rst");
		rdc(`PRPS_OUT_SEL_BASE, 32'h0, "out_sel_rst");
		rdc(`PRPS_STATUS_OFS, 32'h2, "status_rst");
		for (int i = 0; i < 17; i++) begin
			apb(1'b1, 12'h274, (i < 15) ? {26'h0, codes[i]} : 32'(i - 15));
			for (int v = 0; v < 2; v++) begin
				src_pat <= (i < 15 && v == 1) ? (16'h1 << i) : ~(16'h1 << i);
				settle();
				chk("pin29_own", (i < 15) ? 1 : 0, pin_own[29]);
				if (i < 15)
					chk("pin29_out", v, pin_out[29]);
			end
		end
		foreach (vals[k]) begin
			apb(1'b1, 12'h120, 32'(vals[k]));
			pin_pat <= 30'h1 << vals[k];
			settle();
			chk("in8_hi", vals[k] < 30, p_in[8]);
			pin_pat <= ~(30'h1 << vals[k]);
			settle();
			chk("in8_lo", 0, p_in[8]);
		end
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, 12'h280 + 12'(p * 12), 32'h27 + 32'(p));
			apb(1'b1, 12'h134, 32'(32 + 3 * p));
			src_pat <= 16'h0200 << p;
			settle();
			chk("virtual_hi", 1, p_in[13]);
			src_pat <= ~(16'h0200 << p);
			settle();
			chk("virtual_lo", 0, p_in[13]);
		end
		key(32'h40);
		chk("lock_set", 1, lock);
		rdc(`PRPS_OSC_CTRL_OFS, 32'h40, "osc_lock");
		apb(1'b1, `PRPS_IN_SEL_BASE, 32'h5);
		chk("locked_err", 0, err);
		rdc(`PRPS_IN_SEL_BASE, 32'h3F, "locked_sel");
		key(32'h0);
		chk("one_way", 1, lock);
		apb(1'b0, 12'hFFC, 32'h0);
		chk("unmapped_err", 1, err);
		do_reset(1'b0);
		chk("lock_rst", 0, lock);
		apb(1'b1, `PRPS_OSC_CTRL_OFS, 32'h57);
		apb(1'b1, `PRPS_OSC_CTRL_OFS, 32'h40);
		chk("no_key", 0, lock);
		key(32'h40);
		key(32'h0);
		chk("relock_clr", 0, lock);
		apb(1'b1, `PRPS_IN_SEL_BASE, 32'h5);
		apb(1'b1, 12'h104, 32'h6);
		rdc(`PRPS_IN_SEL_BASE, 32'h5, "sel0");
		rdc(12'h104, 32'h6, "sel1");
		rdc(`PRPS_STATUS_OFS, 32'h4, "status_end");
		give_verdict();
	end
endmodule // prps_crossbar_tb_top
`default_nettype wire
